// *** serl_pkg.sv ***
// Constants and types of the serial memory command decoder and region lock
package serl_pkg;

	// Instruction opcodes, sent most significant bit first
	localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
	localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_REGION_LOCK = 8'h01;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_MEM_WRITE = 8'h02;
	localparam logic [7:0] OP_MEM_READ = 8'h03;

	// Lock select codes held in the status byte
	localparam logic [2:0] LOCK_NONE = 3'h0;
	localparam logic [2:0] LOCK_FIRST_QUARTER = 3'h1;
	localparam logic [2:0] LOCK_SECOND_QUARTER = 3'h2;
	localparam logic [2:0] LOCK_THIRD_QUARTER = 3'h3;
	localparam logic [2:0] LOCK_LAST_QUARTER = 3'h4;
	localparam logic [2:0] LOCK_LOWER_HALF = 3'h5;
	localparam logic [2:0] LOCK_FIRST_PAGE = 3'h6;
	localparam logic [2:0] LOCK_LAST_PAGE = 3'h7;

	// Status byte layout
	localparam int LOCK_SEL_LSB = 0;
	localparam int LOCK_SEL_MSB = 2;
	localparam logic [4:0] STATUS_RESERVED = 5'h00;
	localparam logic [7:0] STATUS_BUSY_VALUE = 8'hff;

	// Array geometry
	localparam int MEM_DEPTH = 512;
	localparam int PAGE_BYTES = 16;
	localparam logic [4:0] LAST_PAGE_INDEX = 5'h1f;

	// Values after reset
	localparam logic [2:0] LOCK_SEL_RESET = 3'h0;
	localparam logic WRITE_LATCH_RESET = 1'b0;

	// Self-timed write cycle
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES_DFLT = WRITE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_OPCODE,
		ST_ADDR,
		ST_WDATA,
		ST_RDATA,
		ST_LOCK,
		ST_STATUS,
		ST_IGNORE
	} serl_state_e;

	typedef logic [8:0] serl_addr_t;

	typedef struct packed {
		serl_state_e st;
		logic cs_s1;
		logic cs_s2;
		logic cs_d;
		logic sck_s1;
		logic sck_s2;
		logic sck_d;
		logic si_s1;
		logic si_s2;
		logic wp_s1;
		logic wp_s2;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		serl_addr_t addr;
		logic addr_cnt;
		logic is_write;
		logic [7:0] tx;
		logic so;
		logic so_oe_n;
		logic standby;
		logic wel;
		logic [2:0] lock_sel;
		logic [2:0] lock_new;
		logic frame_ok;
		logic wp_ok;
		logic set_write_latch_cmd_arm;
		logic clear_write_latch_cmd_arm;
		logic busy;
		logic busy_lock;
		logic [16:0] timer;
		logic [15:0][7:0] page_buf;
		logic [15:0] buf_mask;
	} serl_regs_s;

endpackage

// *** serl_core.sv ***
// Serial memory command decoder with write latch, region lock and self-timed writes
//
// How it works
// - Region lock acts only with the write latch set, else ignored.
// - Region lock is command byte 01h then one lock byte.
// - Chip select rising after lock command starts self-timed status write.
// - Extra lock bytes replace earlier ones; the last complete byte counts.
// - After power-up the device is deselected and in standby.
// - No instruction accepted until chip select falls after power-up.
// - Serial output is high impedance after power-up.
// - Write latch clears at power-up; only set-write-latch sets it.
// - A write starts only if chip select rises at the correct count.
// - Opcode 06h sets the write latch.
// - Opcode 04h clears the write latch.
// - Codes 0-4 protect nothing, or one quarter of the array.
// - Code 5 protects lower half, 6 first page, 7 last page.
// - Opcode 05h shifts out lock status and write-in-progress status.
// - Opcode 02h starts a memory write with address then data.
// - Opcode 03h starts a memory read with address, then data returns.
// - Every byte is transferred most significant bit first.
// - Locked addresses stay readable but writes to them are refused.
// - Write latch clears when a byte or page write cycle completes.
// - Status read gives all ones while busy, else status, reserved zero.
// - Writes inhibited while write protect is low; started cycles unaffected.
module serl_core
	import serl_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe_n,
	output logic standby,
	output logic write_busy
);

	serl_regs_s r;
	serl_regs_s next_r;
	logic [7:0] mem [0:MEM_DEPTH-1];
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic can_write;
	logic mem_commit;
	logic [7:0] rx_byte;
	logic [7:0] status_byte;
	serl_addr_t addr_inc;
	serl_addr_t addr_first;

	// Address falls inside the currently locked region
	function automatic logic lock_hit(input logic [2:0] sel, input serl_addr_t a);
		logic hit;
		hit = 1'b0;
		case (sel)
			LOCK_NONE: hit = 1'b0;
			LOCK_FIRST_QUARTER: hit = (a[8:7] == 2'h0);
			LOCK_SECOND_QUARTER: hit = (a[8:7] == 2'h1);
			LOCK_THIRD_QUARTER: hit = (a[8:7] == 2'h2);
			LOCK_LAST_QUARTER: hit = (a[8:7] == 2'h3);
			LOCK_LOWER_HALF: hit = (a[8] == 1'b0);
			LOCK_FIRST_PAGE: hit = (a[8:4] == 5'h00);
			LOCK_LAST_PAGE: hit = (a[8:4] == LAST_PAGE_INDEX);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Edges seen on the second synchroniser stage against a third copy
	assign cs_fall = r.cs_d & ~r.cs_s2;
	assign cs_rise = ~r.cs_d & r.cs_s2;
	assign sck_rise = ~r.sck_d & r.sck_s2;
	assign sck_fall = r.sck_d & ~r.sck_s2;
	assign rx_byte = {r.shreg[6:0], r.si_s2};
	assign addr_inc = r.addr + 9'h001;
	assign addr_first = {r.addr[8], rx_byte};
	assign mem_commit = r.busy & (r.timer == 17'h00000) & ~r.busy_lock;
	assign status_byte = r.busy ? STATUS_BUSY_VALUE : {STATUS_RESERVED, r.lock_sel};
	// Protect input must stay high for the whole frame and at the rise
	assign can_write = r.frame_ok & r.wel & r.wp_ok & r.wp_s2 & ~r.busy;

	always_comb begin
		next_r = r;
		next_r.cs_s1 = cs_n;
		next_r.cs_s2 = r.cs_s1;
		next_r.cs_d = r.cs_s2;
		next_r.sck_s1 = sck;
		next_r.sck_s2 = r.sck_s1;
		next_r.sck_d = r.sck_s2;
		next_r.si_s1 = si;
		next_r.si_s2 = r.si_s1;
		next_r.wp_s1 = wp_n;
		next_r.wp_s2 = r.wp_s1;

		// Self-timed cycle runs on regardless of pins
		if (r.busy) begin
			if (r.timer == 17'h00000) begin
				next_r.busy = 1'b0;
				if (r.busy_lock) begin
					next_r.lock_sel = r.lock_new;
				end else begin
					next_r.wel = 1'b0;
				end
			end else begin
				next_r.timer = r.timer - 17'h00001;
			end
		end

		if (!r.wp_s2) begin
			next_r.wp_ok = 1'b0;
		end

		if (cs_fall) begin
			// Only a falling select leaves standby
			next_r.st = ST_OPCODE;
			next_r.bit_cnt = 3'h0;
			next_r.addr_cnt = 1'b0;
			next_r.frame_ok = 1'b0;
			next_r.set_write_latch_cmd_arm = 1'b0;
			next_r.clear_write_latch_cmd_arm = 1'b0;
			next_r.wp_ok = r.wp_s2;
			next_r.so_oe_n = 1'b1;
		end else if (r.st != ST_STANDBY && cs_rise) begin
			next_r.st = ST_STANDBY;
			next_r.so_oe_n = 1'b1;
			next_r.set_write_latch_cmd_arm = 1'b0;
			next_r.clear_write_latch_cmd_arm = 1'b0;
			if (r.set_write_latch_cmd_arm) begin
				next_r.wel = 1'b1;
			end
			if (r.clear_write_latch_cmd_arm) begin
				next_r.wel = 1'b0;
			end
			if (r.st == ST_LOCK && can_write) begin
				next_r.busy = 1'b1;
				next_r.busy_lock = 1'b1;
				next_r.timer = 17'(WRITE_CYCLES - 1);
			end
			if (r.st == ST_WDATA && can_write && !lock_hit(r.lock_sel, r.addr)) begin
				next_r.busy = 1'b1;
				next_r.busy_lock = 1'b0;
				next_r.timer = 17'(WRITE_CYCLES - 1);
			end
		end else if (r.st != ST_STANDBY && sck_fall) begin
			if (r.st == ST_RDATA || r.st == ST_STATUS) begin
				next_r.so = r.tx[7];
				next_r.tx = {r.tx[6:0], 1'b0};
			end
		end else if (r.st != ST_STANDBY && sck_rise) begin
			next_r.shreg = rx_byte;
			next_r.bit_cnt = r.bit_cnt + 3'h1;
			// Any clock past a byte boundary spoils the count
			next_r.frame_ok = 1'b0;
			next_r.set_write_latch_cmd_arm = 1'b0;
			next_r.clear_write_latch_cmd_arm = 1'b0;
			if (r.bit_cnt == 3'h7) begin
				case (r.st)
					ST_OPCODE: begin
						if (r.busy && rx_byte != OP_READ_STATUS) begin
							next_r.st = ST_IGNORE;
						end else begin
							case (rx_byte)
								OP_SET_WRITE_LATCH: begin
									next_r.set_write_latch_cmd_arm = 1'b1;
									next_r.st = ST_IGNORE;
								end
								OP_CLEAR_WRITE_LATCH: begin
									next_r.clear_write_latch_cmd_arm = 1'b1;
									next_r.st = ST_IGNORE;
								end
								OP_REGION_LOCK: begin
									next_r.st = ST_LOCK;
								end
								OP_READ_STATUS: begin
									next_r.st = ST_STATUS;
									next_r.tx = status_byte;
									next_r.so_oe_n = 1'b0;
								end
								OP_MEM_WRITE: begin
									next_r.st = ST_ADDR;
									next_r.is_write = 1'b1;
								end
								OP_MEM_READ: begin
									next_r.st = ST_ADDR;
									next_r.is_write = 1'b0;
								end
								default: begin
									next_r.st = ST_IGNORE;
								end
							endcase
						end
					end
					ST_ADDR: begin
						if (!r.addr_cnt) begin
							next_r.addr[8] = rx_byte[0];
							next_r.addr_cnt = 1'b1;
						end else begin
							next_r.addr = addr_first;
							if (r.is_write) begin
								next_r.st = ST_WDATA;
								next_r.buf_mask = 16'h0000;
							end else begin
								next_r.st = ST_RDATA;
								next_r.tx = mem[addr_first];
								next_r.so_oe_n = 1'b0;
							end
						end
					end
					ST_WDATA: begin
						// Bytes wrap inside one page
						next_r.page_buf[r.addr[3:0]] = rx_byte;
						next_r.buf_mask[r.addr[3:0]] = 1'b1;
						next_r.addr[3:0] = r.addr[3:0] + 4'h1;
						next_r.frame_ok = 1'b1;
					end
					ST_RDATA: begin
						next_r.addr = addr_inc;
						next_r.tx = mem[addr_inc];
					end
					ST_LOCK: begin
						next_r.lock_new = rx_byte[LOCK_SEL_MSB:LOCK_SEL_LSB];
						next_r.frame_ok = 1'b1;
					end
					ST_STATUS: begin
						next_r.tx = status_byte;
					end
					default: begin
						next_r.st = r.st;
					end
				endcase
			end
		end

		next_r.standby = (next_r.st == ST_STANDBY) & ~next_r.busy;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r <= '0;
			r.st <= ST_STANDBY;
			r.so_oe_n <= 1'b1;
			r.standby <= 1'b1;
			r.wel <= WRITE_LATCH_RESET;
			r.lock_sel <= LOCK_SEL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Page commit at the end of the self-timed cycle
	always_ff @(posedge ref_clk) begin
		if (mem_commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (r.buf_mask[i]) begin
					mem[{r.addr[8:4], 4'(i)}] <= r.page_buf[i];
				end
			end
		end
	end

	assign so = r.so;
	assign so_oe_n = r.so_oe_n;
	assign standby = r.standby;
	assign write_busy = r.busy;

endmodule

// *** serl_core_checker.sv ***
// Pin-level assertions for the serial memory core
module serl_core_checker
	import serl_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic standby,
	input wire logic write_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	int busy_cnt;
	always_ff @(posedge ref_clk) begin
		busy_cnt <= (srst || !write_busy) ? 0 : busy_cnt + 1;
	end
	power_up_a: assert property ($fell(srst) |-> so_oe_n && standby && !write_busy)
		else $error("not idle after reset");
	oe_idle_a: assert property (cs_n [*5] |-> so_oe_n)
		else $error("so driven while deselected");
	oe_select_a: assert property (!so_oe_n |-> !$past(cs_n, 5))
		else $error("so driven without select");
	busy_len_a: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
	busy_start_a: assert property ($rose(write_busy) |-> $past(cs_n) && $past(cs_n, 2))
		else $error("write began while selected");
	busy_frame_a: assert property (!cs_n [*6] |-> !$rose(write_busy))
		else $error("write began mid frame");
	wp_block_a: assert property (!wp_n [*8] |-> !$rose(write_busy))
		else $error("write began under protect");
	so_edge_a: assert property ($changed(so) && !so_oe_n && !$past(so_oe_n)
		|-> !$past(sck, 2)) else $error("so moved outside clock low");
	busy_standby_a: assert property (write_busy |-> !standby)
		else $error("standby during write");
	select_active_a: assert property (!cs_n [*5] |-> !standby)
		else $error("standby while selected");
endmodule

// *** serl_host_model.sv ***
// Host master model in mode 0 or 3 driving the serial memory pins
module serl_host_model (
	input wire logic ref_clk,
	input wire logic so,
	input wire logic so_oe_n,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cpol = 1'b0;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Idle clock level changes only while deselected
	task automatic set_mode(input logic m);
		@(posedge ref_clk);
		sck <= m;
		cpol = m;
		hold(5);
	endtask
	// Every pin level lasts five clocks so the synchronisers see it
	task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
		logic [7:0] rx;
		rx = 8'h00;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		hold(5);
		for (int i = 0; i < ntx + nrx; i++) begin
			if (cpol) begin
				sck <= 1'b0;
			end
			si <= (i < ntx) ? tx[31 - i] : 1'($urandom);
			hold(5);
			sck <= 1'b1;
			if (i >= ntx) begin
				rx = {rx[6:0], so_oe_n ? 1'bx : so};
			end
			hold(5);
			if (!cpol) begin
				sck <= 1'b0;
			end
		end
		hold(5);
		cs_n <= 1'b1;
		si <= ~si;
		rx_valid <= (nrx > 0);
		rx_byte <= rx;
		hold(1);
		rx_valid <= 1'b0;
		hold(5);
	endtask
endmodule

// *** spi_eeprom_region_lock_cmds_tb_top.sv ***
// Self-checking bench for the serial memory core with region lock
module spi_eeprom_region_lock_cmds_tb_top
	import serl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic wp_n = 1'b1;
	logic cs_n, sck, si, so, so_oe_n, standby, write_busy, rx_valid;
	logic [7:0] rx_byte, d;
	logic [7:0] exp_q[$];
	logic [8:0] a;
	int failures = 0;
	int checked = 0;
	always #50 ref_clk = ~ref_clk;
	serl_core #(.WRITE_CYCLES(400)) dut (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n),
		.sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .standby(standby),
		.write_busy(write_busy));
	serl_host_model host (.ref_clk(ref_clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n),
		.sck(sck), .si(si), .rx_valid(rx_valid), .rx_byte(rx_byte));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (exp_q.size() != 0) begin
			failures++;
			$display("CHECK FAILED at %0t: %0d results never seen", $time, exp_q.size());
		end
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic status(input logic [7:0] e);
		exp_q.push_back(e);
		host.frame({OP_READ_STATUS, 24'h0}, 8, 8);
	endtask
	task automatic set_write_latch_cmd();
		host.frame({OP_SET_WRITE_LATCH, 24'h0}, 8, 0);
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 600 && write_busy !== 1'b0; n++)
			@(posedge ref_clk);
		if (n == 600) begin
			failures++;
			$display("CHECK FAILED at %0t: write cycle never ended", $time);
			results();
		end
	endtask
	function automatic logic prot(input logic [2:0] c, input logic [8:0] x);
		case (c)
			LOCK_NONE: return 1'b0;
			LOCK_LOWER_HALF: return !x[8];
			LOCK_FIRST_PAGE: return x[8:4] == 5'h00;
			LOCK_LAST_PAGE: return x[8:4] == 5'h1f;
			default: return x[8:7] == 2'(c - 3'h1);
		endcase
	endfunction
	// Refused writes leave the device idle; others read back
	task automatic mem_wr(input logic [2:0] c);
		logic p;
		p = prot(c, a);
		set_write_latch_cmd();
		host.frame({OP_MEM_WRITE, 7'h0, a, d}, 32, 0);
		status(p ? {5'h0, c} : STATUS_BUSY_VALUE);
		wait_idle();
		if (!p) begin
			exp_q.push_back(d);
			host.frame({OP_MEM_READ, 7'h0, a, 8'h0}, 24, 8);
		end
	endtask
	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("CHECK FAILED at %0t: result with no expectation", $time);
			end else begin
				check(rx_byte, exp_q.pop_front());
			end
		end
	end
	initial begin
		void'($urandom(66101));
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		check({5'h0, so_oe_n, standby, write_busy}, 8'h06);
		host.frame({OP_REGION_LOCK, 8'h05, 16'h0}, 16, 0);
		status(8'h00);
		for (int i = 0; i < 8; i++) begin
			host.set_mode(i[1]);
			set_write_latch_cmd();
			d = i[0] ? {5'h0, 3'($urandom)} : 8'(i);
			host.frame({OP_REGION_LOCK, d, 8'(i), 8'h0}, i[0] ? 24 : 16, 0);
			status(STATUS_BUSY_VALUE);
			wait_idle();
			status(8'(i));
			a = 9'($urandom);
			if (i >= 6) begin
				a[8:4] = {5{i[0]}};
			end
			d = 8'($urandom);
			mem_wr(3'(i));
		end
		a = 9'h000;
		mem_wr(LOCK_LAST_PAGE);
		host.frame({OP_REGION_LOCK, 8'h01, 16'h0}, 16, 0);
		status(8'h07);
		for (int k = 0; k < 3; k++) begin
			wp_n <= (k != 2);
			set_write_latch_cmd();
			if (k == 0) begin
				host.frame({OP_CLEAR_WRITE_LATCH, 24'h0}, 8, 0);
			end
			host.frame({OP_REGION_LOCK, 8'h01, 16'h0}, (k == 1) ? 19 : 16, 0);
			wp_n <= 1'b1;
			status(8'h07);
		end
		results();
	end
endmodule
bind serl_core serl_core_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.ref_clk(ref_clk),
	.srst(srst), .cs_n(cs_n), .sck(sck), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
	.standby(standby), .write_busy(write_busy));
